// ===== hdl/spp_pkg.sv
// constants, register map and mode states of the speed and profile position mode logic
// Overview of operation
// - speed control setpoint is signed, -30000 to 30000 rpm, default zero
// - commanded speed in speed control stays within the configured maximum speed, except while decelerating after the maximum is lowered
// - speed changes follow the ramp step settings, never an instant jump
// - speed control ends once the mode is deselected and the motor stands still
// - speed control also ends at standstill after a halt or an error
// - profile position moves from start to an absolute or relative target
// - acceleration, deceleration and target speed shape each positioning move
// - absolute targets refer to the axis zero, which homing establishes first
// - one option bit: absolute moves only after homing (1) or always (0)
// - two signed 32-bit readbacks: motor position and profile generator position
// - profile speed 1 to 13200 rpm, default 60, clamped to max and ramp limits
// - absolute target range follows the scaling range and enabled software limits
// - relative-to-actual target during a move adds to the current motor position
// - relative-to-target target during a move adds to the running move's target
// - relative move may cross limits only when finished; position first set to 0
// - one mode at a time; a new mode only after the current one ended
// - a mode is normally activated only in operating state 6
package spp_pkg;
   // parameter addresses
   localparam logic [15:0] ADDR_ABS_HOMING  = 16'h062c;
   localparam logic [15:0] ADDR_MOTOR_POS   = 16'h1e1a;
   localparam logic [15:0] ADDR_GEN_POS     = 16'h1f04;
   localparam logic [15:0] ADDR_SPEED_SET   = 16'h2108;
   localparam logic [15:0] ADDR_PROF_SPEED  = 16'h2300;
   localparam logic [15:0] ADDR_ABS_TARGET  = 16'h2302;
   localparam logic [15:0] ADDR_REL_ACTUAL  = 16'h2304;
   localparam logic [15:0] ADDR_REL_TARGET  = 16'h2306;
   localparam logic [15:0] ADDR_STATUS      = 16'h2308;
   // reset values
   localparam logic [15:0] RST_ABS_HOMING   = 16'h0000;
   localparam logic [15:0] RST_SPEED_SET    = 16'h0000;
   localparam logic [15:0] RST_PROF_SPEED   = 16'h003c;
   localparam logic [31:0] RST_POSITION     = 32'h0000_0000;
   // setpoint ranges
   localparam logic signed [15:0] SPEED_SET_MIN  = -16'sd30000;
   localparam logic signed [15:0] SPEED_SET_MAX  = 16'sd30000;
   localparam logic [15:0]        PROF_SPEED_MIN = 16'h0001;
   localparam logic [15:0]        PROF_SPEED_MAX = 16'h3390;
   // operating state that permits activation
   localparam logic [3:0]  OPSTATE_ENABLED  = 4'h6;
   // status field positions
   localparam int          STAT_MODE_LSB    = 0;
   localparam int          STAT_FINISHED    = 2;
   localparam int          STAT_REFUSED     = 3;
   // mode requests
   localparam logic [1:0]  REQ_NONE         = 2'h0;
   localparam logic [1:0]  REQ_SPEED        = 2'h1;
   localparam logic [1:0]  REQ_PROFILE      = 2'h2;
   // mode states
   typedef enum logic [1:0] {
      MODE_IDLE,
      MODE_SPEED,
      MODE_STOPPING,
      MODE_PROFILE
   } spp_mode_t;
endpackage

// ===== hdl/spp_ramp_step.sv
// one ramp step of the commanded speed toward its target
`timescale 1ns/1ps
`default_nettype none
module spp_ramp_step #(
   parameter int W = 17
) (
   input  wire logic signed [W-1:0] current,
   input  wire logic signed [W-1:0] target,
   input  wire logic [W-2:0]        accelStep,
   input  wire logic [W-2:0]        decelStep,
   output logic signed [W-1:0]      nextSpeed
);
   logic signed [W:0] diff;
   logic [W:0]        diffMag;
   logic [W:0]        step;
   logic              speedingUp;

   // accelerate when moving away from zero, otherwise decelerate
   always_comb begin
      diff       = (W+1)'(target) - (W+1)'(current);
      diffMag    = diff[W] ? (W+1)'(-diff) : (W+1)'(diff);
      speedingUp = (current >= 0 && diff > 0) || (current <= 0 && diff < 0);
      step       = speedingUp ? (W+1)'(accelStep) : (W+1)'(decelStep);
      if (diffMag <= step) begin
         nextSpeed = target;
      end else if (diff[W]) begin
         nextSpeed = W'((W+1)'(current) - step);
      end else begin
         nextSpeed = W'((W+1)'(current) + step);
      end
   end
endmodule
`default_nettype wire

// ===== hdl/spp_limit.sv
// symmetric clamp of a signed speed to a magnitude limit
`timescale 1ns/1ps
`default_nettype none
module spp_limit #(
   parameter int W = 17
) (
   input  wire logic signed [W-1:0] value,
   input  wire logic [W-2:0]        limit,
   output logic signed [W-1:0]      limited
);
   logic signed [W-1:0] posLim;

   // clamp into -limit .. +limit
   always_comb begin
      posLim = W'(limit);
      if (value > posLim) begin
         limited = posLim;
      end else if (value < -posLim) begin
         limited = -posLim;
      end else begin
         limited = value;
      end
   end
endmodule
`default_nettype wire

// ===== hdl/spp_mode_logic.sv
// speed control and profile position mode logic with its parameter port
`timescale 1ns/1ps
`default_nettype none
module spp_mode_logic (
   input  wire logic               clock,
   input  wire logic               sys_rst,
   input  wire logic               parWrite,
   input  wire logic               parRead,
   input  wire logic [15:0]        parAddr,
   input  wire logic [31:0]        parWdata,
   output logic [31:0]             parRdata,
   input  wire logic [1:0]         modeRequest,
   input  wire logic [3:0]         opState,
   input  wire logic               haltRequest,
   input  wire logic               errorActive,
   input  wire logic [15:0]        maxSpeed,
   input  wire logic [15:0]        rampSpeedLimit,
   input  wire logic [15:0]        accelStep,
   input  wire logic [15:0]        decelStep,
   input  wire logic               homingValid,
   input  wire logic signed [31:0] motorPosIn,
   input  wire logic signed [31:0] posMinUser,
   input  wire logic signed [31:0] posMaxUser,
   input  wire logic               swLimitEnable,
   input  wire logic signed [31:0] swLimitNeg,
   input  wire logic signed [31:0] swLimitPos,
   output logic signed [16:0]      commandSpeed,
   output logic                    motionFinished,
   output logic                    positionZeroed,
   output logic [1:0]              modeActive
);
   typedef struct packed {
      spp_pkg::spp_mode_t mode;
      logic [15:0]        speedSet;
      logic [15:0]        profSpeed;
      logic [15:0]        absHoming;
      logic [31:0]        absTarget;
      logic [31:0]        relActual;
      logic [31:0]        relTarget;
      logic [31:0]        curTarget;
      logic [31:0]        genPos;
      logic [31:0]        posOffset;
      logic [31:0]        motorPos;
      logic [16:0]        vel;
      logic               refused;
      logic               zeroPulse;
      logic [31:0]        rdData;
   } spp_state_t;

   spp_state_t st_r;
   spp_state_t st_nxt;

   logic signed [16:0] speedLimited;
   logic signed [16:0] rampTarget;
   logic signed [16:0] rampNext;
   logic signed [32:0] remaining;
   logic [32:0]        remainMag;
   logic [15:0]        profLimit;
   logic               finished;
   logic               opEnabled;
   logic               stopCause;
   logic [31:0]        statusWord;

   // smaller of two unsigned magnitudes
   function automatic logic [15:0] minU16(input logic [15:0] a, input logic [15:0] b);
      minU16 = (a < b) ? a : b;
   endfunction

   // absolute target window from scaling range and enabled software limits
   function automatic logic posAllowed(input logic signed [31:0] p);
      logic ok;
      ok = (p >= posMinUser) && (p <= posMaxUser);
      if (swLimitEnable) begin
         ok = ok && (p >= swLimitNeg) && (p <= swLimitPos);
      end
      posAllowed = ok;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // speed shaping
   spp_limit #(
      .W(17)
   ) u_speed_limit (
      .value   (17'(signed'(st_r.speedSet))),
      .limit   (maxSpeed),
      .limited (speedLimited)
   );

   spp_ramp_step #(
      .W(17)
   ) u_ramp (
      .current   (signed'(st_r.vel)),
      .target    (rampTarget),
      .accelStep (accelStep),
      .decelStep (decelStep),
      .nextSpeed (rampNext)
   );

   // ramp target per mode, profile speed limited by distance left
   always_comb begin
      profLimit = minU16(minU16(st_r.profSpeed, maxSpeed), rampSpeedLimit);
      remaining = 33'(signed'(st_r.curTarget)) - 33'(signed'(st_r.genPos));
      remainMag = remaining[32] ? 33'(-remaining) : 33'(remaining);
      rampTarget = 17'sd0;
      case (st_r.mode)
         spp_pkg::MODE_SPEED: begin
            rampTarget = speedLimited;
         end
         spp_pkg::MODE_PROFILE: begin
            // shrinking speed near the target gives the deceleration ramp
            if (remainMag < 33'(profLimit)) begin
               rampTarget = 17'(remainMag[15:0]);
            end else begin
               rampTarget = 17'(profLimit);
            end
            if (remaining[32]) begin
               rampTarget = -rampTarget;
            end
         end
         default: begin
            rampTarget = 17'sd0;
         end
      endcase
   end

   assign finished   = (st_r.genPos == st_r.curTarget) && (st_r.vel == 17'd0);
   assign opEnabled  = (opState == spp_pkg::OPSTATE_ENABLED);
   assign stopCause  = haltRequest || errorActive;
   assign statusWord = {28'h0, st_r.refused, finished, modeActive};

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      logic signed [31:0] wSigned;
      logic signed [32:0] step;
      logic signed [31:0] base;
      logic signed [31:0] newTarget;
      logic               relWrite;
      wSigned   = signed'(parWdata);
      step      = 33'(signed'(rampNext));
      base      = 32'sd0;
      newTarget = 32'sd0;
      relWrite  = 1'b0;
      st_nxt    = st_r;
      st_nxt.zeroPulse = 1'b0;

      // readbacks refresh every cycle
      st_nxt.motorPos = 32'(motorPosIn - signed'(st_r.posOffset));

      // ramp and generator integration
      st_nxt.vel = rampNext;
      if (st_r.mode == spp_pkg::MODE_PROFILE
            && ((step >= 0 && step >= remaining && remaining >= 0)
            || (step < 0 && step <= remaining && remaining < 0))) begin
         st_nxt.genPos = st_r.curTarget;
      end else begin
         st_nxt.genPos = 32'(33'(signed'(st_r.genPos)) + step);
      end
      if (st_r.mode != spp_pkg::MODE_PROFILE) begin
         st_nxt.curTarget = st_nxt.genPos;  // target follows the generator outside positioning
      end

      // mode sequencing, one mode at a time
      case (st_r.mode)
         spp_pkg::MODE_IDLE: begin
            // no new activation while a halt or an error is still present
            if (stopCause) begin
               st_nxt.mode = spp_pkg::MODE_IDLE;
            end else if (opEnabled && modeRequest == spp_pkg::REQ_SPEED) begin
               st_nxt.mode = spp_pkg::MODE_SPEED;
            end else if (opEnabled && modeRequest == spp_pkg::REQ_PROFILE) begin
               st_nxt.mode      = spp_pkg::MODE_PROFILE;
               st_nxt.curTarget = st_r.genPos;
            end
         end
         spp_pkg::MODE_SPEED: begin
            if (stopCause || modeRequest != spp_pkg::REQ_SPEED) begin
               st_nxt.mode = spp_pkg::MODE_STOPPING;
            end
         end
         spp_pkg::MODE_PROFILE: begin
            if (stopCause) begin
               st_nxt.mode = spp_pkg::MODE_STOPPING;
            end else if (modeRequest != spp_pkg::REQ_PROFILE && finished) begin
               st_nxt.mode = spp_pkg::MODE_IDLE;
            end
         end
         spp_pkg::MODE_STOPPING: begin
            if (st_r.vel == 17'd0) begin
               st_nxt.mode = spp_pkg::MODE_IDLE;
            end
         end
         default: begin
            st_nxt.mode = spp_pkg::MODE_IDLE;
         end
      endcase

      // parameter writes
      if (parWrite) begin
         case (parAddr)
            spp_pkg::ADDR_ABS_HOMING: begin
               st_nxt.absHoming = {15'h0, parWdata[0]};
            end
            spp_pkg::ADDR_SPEED_SET: begin
               if (wSigned >= 32'(spp_pkg::SPEED_SET_MIN)
                     && wSigned <= 32'(spp_pkg::SPEED_SET_MAX)) begin
                  st_nxt.speedSet = parWdata[15:0];
               end else begin
                  st_nxt.refused = 1'b1;
               end
            end
            spp_pkg::ADDR_PROF_SPEED: begin
               if (parWdata >= 32'(spp_pkg::PROF_SPEED_MIN)
                     && parWdata <= 32'(spp_pkg::PROF_SPEED_MAX)) begin
                  st_nxt.profSpeed = parWdata[15:0];
               end else begin
                  st_nxt.refused = 1'b1;
               end
            end
            spp_pkg::ADDR_ABS_TARGET: begin
               st_nxt.absTarget = parWdata;
               if (st_r.mode == spp_pkg::MODE_PROFILE) begin
                  if (st_r.absHoming[0] && !homingValid) begin
                     st_nxt.refused = 1'b1;
                  end else if (!posAllowed(wSigned)) begin
                     st_nxt.refused = 1'b1;
                  end else begin
                     st_nxt.curTarget = parWdata;
                  end
               end
            end
            spp_pkg::ADDR_REL_ACTUAL: begin
               st_nxt.relActual = parWdata;
               relWrite = 1'b1;
               base     = signed'(st_r.motorPos);
            end
            spp_pkg::ADDR_REL_TARGET: begin
               st_nxt.relTarget = parWdata;
               relWrite = 1'b1;
               base     = signed'(st_r.curTarget);
            end
            spp_pkg::ADDR_STATUS: begin
               st_nxt.refused = 1'b0;
            end
            default: begin
               st_nxt.refused = st_r.refused;
            end
         endcase
      end

      // relative move start
      if (relWrite && st_r.mode == spp_pkg::MODE_PROFILE && !stopCause) begin
         if (finished) begin
            // standstill start: implicit position set to zero, limits may be crossed
            st_nxt.genPos    = spp_pkg::RST_POSITION;
            st_nxt.posOffset = 32'(motorPosIn);
            st_nxt.curTarget = parWdata;
            st_nxt.vel       = 17'd0;
            st_nxt.zeroPulse = 1'b1;
         end else begin
            newTarget = base + wSigned;
            if (posAllowed(newTarget)) begin
               st_nxt.curTarget = newTarget;
            end else begin
               st_nxt.refused = 1'b1;
            end
         end
      end

      // halt or error overrides any target: stop where the generator stands
      if (st_r.mode == spp_pkg::MODE_STOPPING) begin
         st_nxt.curTarget = st_nxt.genPos;
      end

      // read data, one cycle after the read strobe
      if (parRead) begin
         case (parAddr)
            spp_pkg::ADDR_ABS_HOMING: st_nxt.rdData = {16'h0, st_r.absHoming};
            spp_pkg::ADDR_MOTOR_POS:  st_nxt.rdData = st_r.motorPos;
            spp_pkg::ADDR_GEN_POS:    st_nxt.rdData = st_r.genPos;
            spp_pkg::ADDR_SPEED_SET:  st_nxt.rdData = 32'(signed'(st_r.speedSet));
            spp_pkg::ADDR_PROF_SPEED: st_nxt.rdData = {16'h0, st_r.profSpeed};
            spp_pkg::ADDR_ABS_TARGET: st_nxt.rdData = st_r.absTarget;
            spp_pkg::ADDR_REL_ACTUAL: st_nxt.rdData = st_r.relActual;
            spp_pkg::ADDR_REL_TARGET: st_nxt.rdData = st_r.relTarget;
            spp_pkg::ADDR_STATUS:     st_nxt.rdData = statusWord;
            default:                  st_nxt.rdData = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         st_r.mode      <= spp_pkg::MODE_IDLE;
         st_r.speedSet  <= spp_pkg::RST_SPEED_SET;
         st_r.profSpeed <= spp_pkg::RST_PROF_SPEED;
         st_r.absHoming <= spp_pkg::RST_ABS_HOMING;
         st_r.absTarget <= spp_pkg::RST_POSITION;
         st_r.relActual <= spp_pkg::RST_POSITION;
         st_r.relTarget <= spp_pkg::RST_POSITION;
         st_r.curTarget <= spp_pkg::RST_POSITION;
         st_r.genPos    <= spp_pkg::RST_POSITION;
         st_r.posOffset <= spp_pkg::RST_POSITION;
         st_r.motorPos  <= spp_pkg::RST_POSITION;
         st_r.vel       <= 17'h0_0000;
         st_r.refused   <= 1'b0;
         st_r.zeroPulse <= 1'b0;
         st_r.rdData    <= 32'h0000_0000;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs
   assign parRdata       = st_r.rdData;
   assign commandSpeed   = signed'(st_r.vel);
   assign motionFinished = finished;
   assign positionZeroed = st_r.zeroPulse;
   assign modeActive     = (st_r.mode == spp_pkg::MODE_SPEED) ? spp_pkg::REQ_SPEED :
                           (st_r.mode == spp_pkg::MODE_PROFILE) ? spp_pkg::REQ_PROFILE :
                           spp_pkg::REQ_NONE;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   logic [16:0] absVel;
   logic [16:0] velDelta;
   logic [16:0] velStep;
   assign absVel   = st_r.vel[16] ? 17'(-signed'(st_r.vel)) : st_r.vel;
   assign velDelta = 17'(signed'(st_r.vel) - signed'(st_nxt.vel));
   assign velStep  = velDelta[16] ? 17'(-signed'(velDelta)) : velDelta;

   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   sequence absWriteLocked;
      parWrite && parAddr == spp_pkg::ADDR_ABS_TARGET && st_r.mode == spp_pkg::MODE_PROFILE
         && st_r.absHoming[0] && !homingValid;
   endsequence

   sequence relStartFromRest;
      parWrite && (parAddr == spp_pkg::ADDR_REL_ACTUAL || parAddr == spp_pkg::ADDR_REL_TARGET)
         && st_r.mode == spp_pkg::MODE_PROFILE && !stopCause && finished;
   endsequence

   speed_setpoint_a: assert property (
      signed'(st_r.speedSet) >= spp_pkg::SPEED_SET_MIN
         && signed'(st_r.speedSet) <= spp_pkg::SPEED_SET_MAX)
      else $error("speed setpoint out of range");

   speed_limit_a: assert property (
      (st_r.mode == spp_pkg::MODE_SPEED && absVel <= 17'(maxSpeed)
         && st_nxt.mode == spp_pkg::MODE_SPEED && $stable(maxSpeed))
      |=> absVel <= 17'(maxSpeed))
      else $error("speed command above maximum speed");

   ramp_step_a: assert property (
      (st_r.mode == spp_pkg::MODE_SPEED)
      |-> (velStep <= 17'(accelStep) || velStep <= 17'(decelStep)))
      else $error("commanded speed jumped beyond ramp step");

   stop_on_halt_a: assert property (
      (st_r.mode == spp_pkg::MODE_SPEED && haltRequest)
      |=> st_r.mode == spp_pkg::MODE_STOPPING ##1 (st_r.mode != spp_pkg::MODE_SPEED))
      else $error("halt did not end speed control");

   abs_homing_a: assert property (
      absWriteLocked |=> st_r.curTarget == $past(st_r.curTarget) && st_r.refused)
      else $error("absolute move taken without homing");

   prof_speed_a: assert property (
      st_r.profSpeed >= spp_pkg::PROF_SPEED_MIN && st_r.profSpeed <= spp_pkg::PROF_SPEED_MAX)
      else $error("profile speed out of range");

   rel_zero_a: assert property (
      relStartFromRest |=> st_r.genPos == 32'h0 && st_r.zeroPulse
         && st_r.curTarget == $past(parWdata) ##1 !st_r.zeroPulse)
      else $error("standstill relative move did not zero position");

   readback_a: assert property (
      ##1 st_r.motorPos == 32'($past(motorPosIn) - signed'($past(st_r.posOffset))))
      else $error("motor position readback not refreshed");
endmodule
`default_nettype wire

// ===== bench/spp_master_model.sv
// fieldbus master model: parameter writes and reads on the strobe port
`timescale 1ns/1ps
`default_nettype none
module spp_master_model (
   input  wire logic        clock,
   input  wire logic [31:0] parRdata,
   output logic             parWrite,
   output logic             parRead,
   output logic [15:0]      parAddr,
   output logic [31:0]      parWdata
);
   initial begin
      parWrite = 1'b0;
      parRead  = 1'b0;
      parAddr  = 16'h0000;
      parWdata = 32'h0000_0000;
   end
   // one-cycle write strobe; new targets only come through writes
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge clock);
      #1 parWrite = 1'b1;
      parAddr  = a;
      parWdata = d;
      @(posedge clock);
      #1 parWrite = 1'b0;
      parWdata = ~d;
   endtask
   // one-cycle read strobe, data taken one cycle later
   task automatic rd(input logic [15:0] a, output logic [31:0] v);
      @(posedge clock);
      #1 parRead = 1'b1;
      parAddr = a;
      @(posedge clock);
      #1 parRead = 1'b0;
      v = parRdata;
   endtask
endmodule
`default_nettype wire

// ===== bench/spp_mode_logic_bench.sv
// self-checking bench of the speed and profile position mode logic
`timescale 1ns/1ps
`default_nettype none
module spp_mode_logic_bench;
   logic clock = 1'b0, sys_rst = 1'b1, parWrite, parRead, haltRequest = 1'b0;
   logic errorActive = 1'b0, homingValid = 1'b0, swLimitEnable = 1'b0;
   logic motionFinished, positionZeroed;
   logic [15:0] parAddr, maxSpeed = 16'h0064, accelStep = 16'h000a, decelStep = 16'h000a;
   logic [15:0] rampLim = 16'h3390;
   logic [31:0] parWdata, parRdata, v;
   logic [1:0] modeRequest = 2'h0, modeActive;
   logic [3:0] opState = 4'h6;
   logic signed [31:0] motorPosIn = 32'sd0, swLimitPos = 32'sd100000;
   logic signed [16:0] commandSpeed;
   int err_total = 0, check_count = 0, cyc = 0, i;
   always #25 clock = ~clock;
   spp_master_model m (.clock(clock), .parRdata(parRdata), .parWrite(parWrite),
      .parRead(parRead), .parAddr(parAddr), .parWdata(parWdata));
   spp_mode_logic dut (.clock(clock), .sys_rst(sys_rst), .parWrite(parWrite),
      .parRead(parRead), .parAddr(parAddr), .parWdata(parWdata), .parRdata(parRdata),
      .modeRequest(modeRequest), .opState(opState), .haltRequest(haltRequest),
      .errorActive(errorActive), .maxSpeed(maxSpeed), .rampSpeedLimit(rampLim),
      .accelStep(accelStep), .decelStep(decelStep), .homingValid(homingValid),
      .motorPosIn(motorPosIn), .posMinUser(-32'sd100000), .posMaxUser(32'sd100000),
      .swLimitEnable(swLimitEnable), .swLimitNeg(-32'sd100000), .swLimitPos(swLimitPos),
      .commandSpeed(commandSpeed), .motionFinished(motionFinished),
      .positionZeroed(positionZeroed), .modeActive(modeActive));
   ////////////////////////////////////////////////////////////////////////////////
   // verdict and run end
   task automatic results;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   // bounded wait for the end of a positioning move
   task automatic waitFin;
      for (int k = 0; k < 400 && motionFinished !== 1'b1; k++) @(posedge clock);
      #1;
      chk1(motionFinished, 1'b1);
   endtask
   // cycle ceiling against hangs
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         results();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // test sequence
   initial begin
      repeat (5) @(posedge clock);
      #1 sys_rst = 1'b0;
      m.rd(16'h2108, v); chk32(v, 32'h0);
      m.rd(16'h2300, v); chk32(v, 32'h3c);
      m.rd(16'h062c, v); chk32(v, 32'h0);
      m.rd(16'h1e1a, v); chk32(v, 32'h0);
      m.rd(16'h1f04, v); chk32(v, 32'h0);
      m.wr(16'h2108, 32'd30001);
      m.rd(16'h2108, v); chk32(v, 32'h0);
      m.wr(16'h2108, -32'sd30000);
      m.rd(16'h2108, v); chk32(v, 32'hffff8ad0);
      m.wr(16'h2108, 32'd30000);
      // speed mode left once by an error, once by a halt, once by deselection
      for (i = 0; i < 3; i++) begin
         #1 modeRequest = 2'h1;
         decelStep = 16'h000a;
         for (int k = 0; k < 20 && modeActive !== 2'h1; k++) @(posedge clock);
         @(posedge clock); #1;
         chk1(commandSpeed <= 17'sd20, 1'b1);
         repeat (15) @(posedge clock);
         #1 chk32(32'(commandSpeed), 32'd100);
         decelStep = 16'h0019;
         if (i == 0) errorActive = 1'b1;
         else if (i == 1) haltRequest = 1'b1;
         else modeRequest = 2'h0;
         repeat (8) @(posedge clock);
         #1 chk32(32'(commandSpeed), 32'd0);
         chk32(32'(modeActive), 32'd0);
         errorActive = 1'b0;
         haltRequest = 1'b0;
         modeRequest = 2'h0;
         repeat (2) @(posedge clock);
      end
      // profile position
      #1 modeRequest = 2'h2;
      motorPosIn = 32'sd700;
      repeat (3) @(posedge clock);
      m.wr(16'h2300, 32'd13201);
      m.rd(16'h2300, v); chk32(v, 32'h3c);
      m.wr(16'h2300, 32'd50);
      m.rd(16'h2300, v); chk32(v, 32'd50);
      m.wr(16'h062c, 32'd1);
      m.wr(16'h2308, 32'd0);
      m.rd(16'h2308, v); chk1(v[3], 1'b0);
      m.wr(16'h2302, 32'd1000);
      m.rd(16'h2308, v); chk1(v[3], 1'b1);
      m.wr(16'h2308, 32'd0);
      homingValid = 1'b1;
      m.wr(16'h2302, 32'd1000);
      waitFin();
      m.rd(16'h1f04, v); chk32(v, 32'd1000);
      m.wr(16'h2306, 32'd200);
      chk1(positionZeroed, 1'b1);
      waitFin();
      m.rd(16'h1f04, v); chk32(v, 32'd200);
      m.rd(16'h1e1a, v); chk32(v, 32'd0);
      #1 motorPosIn = 32'sd900;
      repeat (2) @(posedge clock);
      m.rd(16'h1e1a, v); chk32(v, 32'd200);
      m.wr(16'h2302, 32'd1000);
      repeat (3) @(posedge clock);
      m.wr(16'h2306, 32'd100);
      waitFin();
      m.rd(16'h1f04, v); chk32(v, 32'd1100);
      m.wr(16'h2302, 32'd3000);
      repeat (3) @(posedge clock);
      m.wr(16'h2304, 32'd50);
      waitFin();
      m.rd(16'h1f04, v); chk32(v, 32'd250);
      #1 swLimitEnable = 1'b1;
      swLimitPos = 32'sd5000;
      m.wr(16'h2302, 32'd6000);
      m.rd(16'h2308, v); chk1(v[3], 1'b1);
      m.rd(16'h1f04, v); chk32(v, 32'd250);
      rampLim = 16'h001e;
      m.wr(16'h2302, 32'd1250);
      repeat (10) @(posedge clock);
      #1 chk32(32'(commandSpeed), 32'd30);
      m.rd(16'h3000, v); chk32(v, 32'd0);
      results();
   end
endmodule
`default_nettype wire
